// *** rtl/dgw_defines.vh ***
`ifndef DGW_DEFINES_VH
`define DGW_DEFINES_VH
// loudness span and block sizes in samples
`define DGW_SPAN_SAMPLES      256
`define DGW_BLOCK_SAMPLES     512
// audio blocks per sync frame (32 ms frame)
`define DGW_BLOCKS_PER_FRAME  6
`define DGW_FRAME_MS          32
// level format: signed 16 bit, 1/20 dB per lsb
`define DGW_LVL_W             16
// clip level 0 dB FS
`define DGW_CLIP_LEVEL        16'sh0000
// quantizer steps in level lsbs (0.2 dB and 0.4 dB)
`define DGW_LINE_STEP         16'h0004
`define DGW_RF_STEP           16'h0008
// time constant selector codes
`define DGW_TC_FAST_ATK       2'h0
`define DGW_TC_SLOW_ATK       2'h1
`define DGW_TC_SLOW_DEC       2'h2
`define DGW_TC_FAST_DEC       2'h3
// smoothing shifts for each time constant
`define DGW_SH_FAST_ATK       4'h1
`define DGW_SH_SLOW_ATK       4'h3
`define DGW_SH_SLOW_DEC       4'h7
`define DGW_SH_FAST_DEC       4'h4
// default thresholds in level lsbs
`define DGW_ATK_THR           16'h0064
`define DGW_DEC_THR           16'h00C8
`endif

// *** rtl/dgw_gain_word_gen.v ***
// Overview of operation
// - dialogue level and line word per block, rf word per frame
// - block loudness is mean of two spans
// - per-channel loudness summed to program loudness
// - worst case downmix peak taken
// - loudness and peak offset by dialogue level
// - rf path covers whole sync frame
// - profile curve maps loudness to static gain
// - attack or decay constant by direction
// - fast attack above attack threshold
// - fast decay above decay threshold
// - max gain is clip minus peak
// - clamp static gain, smooth gain changes
// - line and rf paths run independently
// - line 0.2 dB steps, rf 0.4 dB
// - limiting words on downmix clipping
// - loudness is unweighted sum of active channel levels
`timescale 1ns/100ps
`include "dgw_defines.vh"

// one smoothing and limiting path, shared by line and rf rate
module dgw_path #(
    parameter W = 16
) (
    input  wire                i_clock,
    input  wire                i_sys_rst,
    input  wire                i_update,
    input  wire signed [W-1:0] i_loud,
    input  wire signed [W-1:0] i_peak,
    input  wire signed [W-1:0] i_pro_knee,
    input  wire        [1:0]   i_pro_slope,
    input  wire        [W-1:0] i_atk_thr,
    input  wire        [W-1:0] i_dec_thr,
    input  wire        [W-1:0] i_step,
    output reg  signed [W-1:0] o_word,
    output reg                 o_limit,
    output reg         [1:0]   o_tc
);
    reg  signed [W-1:0] smooth_reg;
    reg  signed [W-1:0] gain_reg;
    reg  signed [W:0]   diff;
    reg  signed [W:0]   over;
    reg  signed [W-1:0] stat_gain;
    reg  signed [W-1:0] max_gain;
    reg  signed [W-1:0] target;
    reg         [1:0]   tc;
    reg         [3:0]   sh;
    reg  signed [W:0]   dl;
    reg  signed [W:0]   dg;
    reg  signed [W-1:0] gain_next;
    reg  signed [W-1:0] q;

    always @* begin
        diff = {i_loud[W-1], i_loud} - {smooth_reg[W-1], smooth_reg};
        if (diff > 0) begin
            if (diff > $signed({1'b0, i_atk_thr})) begin
                tc = `DGW_TC_FAST_ATK;
            end else begin
                tc = `DGW_TC_SLOW_ATK;
            end
        end else begin
            if ((-diff) > $signed({1'b0, i_dec_thr})) begin
                tc = `DGW_TC_FAST_DEC;
            end else begin
                tc = `DGW_TC_SLOW_DEC;
            end
        end
        case (tc)
            `DGW_TC_FAST_ATK: sh = `DGW_SH_FAST_ATK;
            `DGW_TC_SLOW_ATK: sh = `DGW_SH_SLOW_ATK;
            `DGW_TC_SLOW_DEC: sh = `DGW_SH_SLOW_DEC;
            default:          sh = `DGW_SH_FAST_DEC;
        endcase
        // profile: cut above the knee by slope, null below
        over = {i_loud[W-1], i_loud} - {i_pro_knee[W-1], i_pro_knee};
        if (over > 0) begin
            stat_gain = -((over[W-1:0] >>> 2) * $signed({1'b0, i_pro_slope}));
        end else begin
            stat_gain = {W{1'b0}};
        end
        max_gain = `DGW_CLIP_LEVEL - i_peak;
        o_limit = stat_gain > max_gain;
        target = o_limit ? max_gain : stat_gain;
        dg = {target[W-1], target} - {gain_reg[W-1], gain_reg};
        dg = dg >>> sh;
        gain_next = gain_reg + dg[W-1:0];
        if (o_limit && (gain_next > max_gain)) begin
            gain_next = max_gain;
        end
        dl = diff >>> sh;
        q = gain_next - (gain_next % $signed(i_step));
        if (q > gain_next) begin
            q = q - $signed(i_step);
        end
    end

    always @(posedge i_clock) begin
        if (i_sys_rst) begin
            smooth_reg <= {W{1'b0}};
            gain_reg   <= {W{1'b0}};
            o_word     <= {W{1'b0}};
            o_tc       <= 2'h0;
        end else if (i_update) begin
            smooth_reg <= smooth_reg + dl[W-1:0];
            gain_reg   <= gain_next;
            o_word     <= q;
            o_tc       <= tc;
        end
    end
endmodule // dgw_path

module dgw_gain_word_gen #(
    parameter CH  = 6,
    parameter W   = 16,
    parameter SPN = `DGW_SPAN_SAMPLES,
    parameter BPF = `DGW_BLOCKS_PER_FRAME
) (
    input  wire            i_clock,
    input  wire            i_sys_rst,
    input  wire            i_in_valid,
    output wire            o_in_ready,
    input  wire [CH*W-1:0] i_ch_loud,
    input  wire [CH-1:0]   i_ch_active,
    input  wire [W-1:0]    i_peak_front,
    input  wire [W-1:0]    i_peak_center,
    input  wire [W-1:0]    i_peak_surr,
    input  wire [W-1:0]    i_cmix_gain,
    input  wire [W-1:0]    i_smix_gain,
    input  wire [W-1:0]    i_dial_level,
    input  wire [W-1:0]    i_line_knee,
    input  wire [1:0]      i_line_slope,
    input  wire [W-1:0]    i_rf_knee,
    input  wire [1:0]      i_rf_slope,
    output wire            o_out_valid,
    input  wire            i_out_ready,
    output wire [W-1:0]    o_line_word,
    output wire            o_line_limit,
    output wire            o_frame_word,
    output wire [W-1:0]    o_rf_word,
    output wire            o_rf_limit,
    output wire [W-1:0]    o_dial_out
);
    localparam CW = 10;
    localparam OW = 3 * W + 3;

    reg  [CW-1:0]   cnt_reg;
    reg             half_reg;
    reg  [2:0]      blk_reg;
    reg  [W+13:0]   acc_reg;
    reg  [W-1:0]    span0_reg;
    reg  [W-1:0]    bpk_reg;
    reg  [W+3:0]    facc_reg;
    reg  [W-1:0]    fpk_reg;
    reg             line_upd_reg;
    reg             rf_upd_reg;
    reg  [W-1:0]    line_l_reg;
    reg  [W-1:0]    line_p_reg;
    reg  [W-1:0]    rf_l_reg;
    reg  [W-1:0]    rf_p_reg;
    reg             emit_reg;
    reg             emit_rf_reg;
    reg  [W+3:0]    sum;
    reg  [W:0]      dmx_c;
    reg  [W:0]      dmx_s;
    reg  [W-1:0]    pk;
    integer         k;

    wire            take = i_in_valid && o_in_ready;
    wire [W-1:0]    line_word;
    wire [W-1:0]    rf_word;
    wire            line_lim;
    wire            rf_lim;
    wire [OW-1:0]   out_data;
    wire            buf_in_ready;
    wire [W+13:0]   span_avg = (acc_reg + {10'h000, sum}) / SPN[W+13:0];
    wire [W+3:0]    span_mean = ({4'h0, span0_reg} + span_avg[W+3:0]) >> 1;
    wire [W+3:0]    rf_mean = (facc_reg + span_mean) / BPF[W+3:0];
    wire [W-1:0]    blk_pk = (pk > bpk_reg) ? pk : bpk_reg;
    wire [W-1:0]    frm_pk = (blk_pk > fpk_reg) ? blk_pk : fpk_reg;

    assign o_in_ready = buf_in_ready;

    always @* begin
        sum = {(W+4){1'b0}};
        for (k = 0; k < CH; k = k + 1) begin
            if (i_ch_active[k]) begin
                sum = sum + {4'h0, i_ch_loud[k*W +: W]};
            end
        end
        dmx_c = {1'b0, i_peak_front} + {1'b0, i_peak_center}
              - {1'b0, i_cmix_gain};
        dmx_s = {1'b0, i_peak_front} + {1'b0, i_peak_surr}
              - {1'b0, i_smix_gain};
        pk = i_peak_front;
        if (dmx_c[W-1:0] > pk) begin
            pk = dmx_c[W-1:0];
        end
        if (dmx_s[W-1:0] > pk) begin
            pk = dmx_s[W-1:0];
        end
    end

    always @(posedge i_clock) begin
        if (i_sys_rst) begin
            cnt_reg      <= {CW{1'b0}};
            half_reg     <= 1'b0;
            blk_reg      <= 3'h0;
            acc_reg      <= {(W+14){1'b0}};
            span0_reg    <= {W{1'b0}};
            bpk_reg      <= {W{1'b0}};
            facc_reg     <= {(W+4){1'b0}};
            fpk_reg      <= {W{1'b0}};
            line_upd_reg <= 1'b0;
            rf_upd_reg   <= 1'b0;
            line_l_reg   <= {W{1'b0}};
            line_p_reg   <= {W{1'b0}};
            rf_l_reg     <= {W{1'b0}};
            rf_p_reg     <= {W{1'b0}};
            emit_reg     <= 1'b0;
            emit_rf_reg  <= 1'b0;
        end else begin
            line_upd_reg <= 1'b0;
            rf_upd_reg   <= 1'b0;
            emit_reg     <= line_upd_reg;
            emit_rf_reg  <= rf_upd_reg;
            if (take) begin
                if (cnt_reg == SPN[CW-1:0] - 1'b1) begin
                    cnt_reg <= {CW{1'b0}};
                    acc_reg <= {(W+14){1'b0}};
                end else begin
                    cnt_reg <= cnt_reg + 1'b1;
                    acc_reg <= acc_reg + {10'h000, sum};
                end
                // running peak over the block, restarted at its first sample
                if (cnt_reg == {CW{1'b0}} && !half_reg) begin
                    bpk_reg <= pk;
                end else if (pk > bpk_reg) begin
                    bpk_reg <= pk;
                end
                if (cnt_reg == SPN[CW-1:0] - 1'b1) begin
                    half_reg <= ~half_reg;
                    if (!half_reg) begin
                        span0_reg <= span_avg[W-1:0];
                    end else begin
                        line_l_reg <= span_mean[W-1:0]
                                    - i_dial_level;
                        line_p_reg <= blk_pk + i_dial_level;
                        line_upd_reg <= 1'b1;
                        if (blk_reg == BPF[2:0] - 1'b1) begin
                            blk_reg    <= 3'h0;
                            rf_l_reg   <= rf_mean[W-1:0]
                                        - i_dial_level;
                            rf_p_reg   <= frm_pk + i_dial_level;
                            rf_upd_reg <= 1'b1;
                            facc_reg   <= {(W+4){1'b0}};
                            fpk_reg    <= {W{1'b0}};
                        end else begin
                            blk_reg  <= blk_reg + 1'b1;
                            facc_reg <= facc_reg + span_mean;
                            fpk_reg  <= frm_pk;
                        end
                    end
                end
            end
        end
    end

    // both paths run side by side on their own update pulses
    dgw_path #(.W(W)) u_line (
        .i_clock    (i_clock),
        .i_sys_rst  (i_sys_rst),
        .i_update   (line_upd_reg),
        .i_loud     (line_l_reg),
        .i_peak     (line_p_reg),
        .i_pro_knee (i_line_knee),
        .i_pro_slope(i_line_slope),
        .i_atk_thr  (`DGW_ATK_THR),
        .i_dec_thr  (`DGW_DEC_THR),
        .i_step     (`DGW_LINE_STEP),
        .o_word     (line_word),
        .o_limit    (line_lim),
        .o_tc       ()
    );

    dgw_path #(.W(W)) u_rf (
        .i_clock    (i_clock),
        .i_sys_rst  (i_sys_rst),
        .i_update   (rf_upd_reg),
        .i_loud     (rf_l_reg),
        .i_peak     (rf_p_reg),
        .i_pro_knee (i_rf_knee),
        .i_pro_slope(i_rf_slope),
        .i_atk_thr  (`DGW_ATK_THR),
        .i_dec_thr  (`DGW_DEC_THR),
        .i_step     (`DGW_RF_STEP),
        .o_word     (rf_word),
        .o_limit    (rf_lim),
        .o_tc       ()
    );

    dgw_buf2 #(.W(OW)) u_buf (
        .i_clock    (i_clock),
        .i_sys_rst  (i_sys_rst),
        .i_valid    (emit_reg),
        .o_ready    (buf_in_ready),
        .i_data     ({line_lim, line_word, emit_rf_reg, rf_lim, rf_word,
                      i_dial_level}),
        .o_valid    (o_out_valid),
        .i_ready    (i_out_ready),
        .o_data     (out_data)
    );

    assign o_line_limit = out_data[OW-1];
    assign o_line_word  = out_data[OW-2 -: W];
    assign o_frame_word = out_data[2*W+1];
    assign o_rf_limit   = out_data[2*W];
    assign o_rf_word    = out_data[2*W-1 -: W];
    assign o_dial_out   = out_data[W-1:0];
endmodule // dgw_gain_word_gen

// two-entry buffer, index addressed
module dgw_buf2 #(
    parameter W = 8
) (
    input  wire         i_clock,
    input  wire         i_sys_rst,
    input  wire         i_valid,
    output wire         o_ready,
    input  wire [W-1:0] i_data,
    output wire         o_valid,
    input  wire         i_ready,
    output wire [W-1:0] o_data
);
    reg [W-1:0] mem_reg [0:1];
    reg         wp_reg;
    reg         rp_reg;
    reg [1:0]   cnt_reg;
    wire        wr = i_valid && (cnt_reg != 2'h2);
    wire        rd = o_valid && i_ready;

    assign o_ready = (cnt_reg == 2'h0);
    assign o_valid = (cnt_reg != 2'h0);
    assign o_data  = mem_reg[rp_reg];

    always @(posedge i_clock) begin
        if (i_sys_rst) begin
            wp_reg     <= 1'b0;
            rp_reg     <= 1'b0;
            cnt_reg    <= 2'h0;
            mem_reg[0] <= {W{1'b0}};
            mem_reg[1] <= {W{1'b0}};
        end else begin
            if (wr) begin
                mem_reg[wp_reg] <= i_data;
                wp_reg <= ~wp_reg;
            end
            if (rd) begin
                rp_reg <= ~rp_reg;
            end
            cnt_reg <= cnt_reg + {1'b0, wr} - {1'b0, rd};
        end
    end
endmodule // dgw_buf2

// *** dv/dgw_gain_word_gen_asserts.sv ***
`timescale 1ns/100ps
module dgw_gain_word_gen_asserts #(
    parameter W   = 16,
    parameter SPN = 256,
    parameter BPF = 6
) (
    input wire         i_clock,
    input wire         i_sys_rst,
    input wire         i_in_valid,
    input wire         o_in_ready,
    input wire         o_out_valid,
    input wire         i_out_ready,
    input wire [W-1:0] o_line_word,
    input wire         o_line_limit,
    input wire         o_frame_word,
    input wire [W-1:0] o_rf_word,
    input wire [W-1:0] o_dial_out,
    input wire [W-1:0] i_dial_level
);
    localparam BLK = 2*SPN;
    reg  [15:0] scnt_reg;
    reg  [7:0]  ecnt_reg;
    wire        take    = i_in_valid && o_in_ready;
    wire        pop     = o_out_valid && i_out_ready;
    wire        blk_end = take && (scnt_reg == BLK-1);
    // samples taken within the block, entries popped within the frame
    always @(posedge i_clock) begin
        if (i_sys_rst) begin
            scnt_reg <= 16'h0000;
            ecnt_reg <= 8'h00;
        end else begin
            if (take)
                scnt_reg <= blk_end ? 16'h0000 : scnt_reg + 16'h0001;
            if (pop)
                ecnt_reg <= (ecnt_reg == BPF-1) ? 8'h00 : ecnt_reg + 8'h01;
        end
    end
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_sys_rst);
    sequence s_block_end;
        blk_end;
    endsequence
    sequence s_word_up;
        !o_out_valid [*2] ##1 o_out_valid;
    endsequence
    a_word_latency: assert property (s_block_end |=> s_word_up)
        else $error("word not offered three cycles after block end");
    a_word_origin: assert property ($rose(o_out_valid) |-> $past(blk_end, 3))
        else $error("word offered without a finished block");
    a_refuse_full: assert property (o_out_valid |-> !o_in_ready)
        else $error("input accepted while buffer holds a word");
    a_entry_stands: assert property (o_out_valid && !i_out_ready |=>
        o_out_valid && $stable(o_line_word) && $stable(o_rf_word)
        && $stable(o_frame_word) && $stable(o_line_limit))
        else $error("stalled word changed");
    a_line_quant: assert property (o_out_valid |-> o_line_word[1:0] == 2'h0)
        else $error("line word off its step");
    a_rf_quant: assert property (pop && o_frame_word |-> o_rf_word[2:0] == 3'h0)
        else $error("rf word off its step");
    a_frame_rate: assert property (pop |-> o_frame_word == (ecnt_reg == BPF-1))
        else $error("frame word not on every sixth block");
    a_dial_echo: assert property (o_out_valid |-> o_dial_out == i_dial_level)
        else $error("dialogue level not carried with word");
endmodule // dgw_gain_word_gen_asserts

// *** dv/dgw_sink.sv ***
`timescale 1ns/100ps
module dgw_sink (
    input  wire        i_clock,
    input  wire        i_sys_rst,
    input  wire        i_slow,
    input  wire        i_out_valid,
    output reg         o_out_ready,
    input  wire [15:0] i_line_word,
    input  wire        i_line_limit,
    input  wire        i_frame_word,
    input  wire [15:0] i_rf_word,
    input  wire        i_rf_limit,
    output reg  [7:0]  o_entries,
    output reg  [7:0]  o_frames,
    output reg  [15:0] o_line_word,
    output reg         o_line_limit,
    output reg  [15:0] o_rf_word,
    output reg         o_rf_limit
);
    reg [1:0] pace_reg;
    always @(posedge i_clock) begin
        if (i_sys_rst) begin
            pace_reg     <= 2'h0;
            o_out_ready  <= 1'b0;
            o_entries    <= 8'h00;
            o_frames     <= 8'h00;
            o_line_word  <= 16'h0000;
            o_line_limit <= 1'b0;
            o_rf_word    <= 16'h0000;
            o_rf_limit   <= 1'b0;
        end else begin
            pace_reg    <= pace_reg + 2'h1;
            // slow consumer accepts one cycle in four
            o_out_ready <= !i_slow || (pace_reg == 2'h3);
            if (i_out_valid && o_out_ready) begin
                o_entries    <= o_entries + 8'h01;
                o_line_word  <= i_line_word;
                o_line_limit <= i_line_limit;
                if (i_frame_word) begin
                    o_frames  <= o_frames + 8'h01;
                    o_rf_word <= i_rf_word;
                    o_rf_limit <= i_rf_limit;
                end
            end
        end
    end
endmodule // dgw_sink

// *** dv/dgw_gain_word_gen_bench.sv ***
`timescale 1ns/100ps
module dgw_gain_word_gen_bench;
    localparam SPN = 4;
    localparam BLK = 2*SPN;
    reg          i_clock;
    reg          i_sys_rst;
    reg          in_valid;
    reg          slow;
    reg  [95:0]  ch_loud;
    reg  [5:0]   ch_active;
    reg  [15:0]  front;
    reg  [15:0]  dial;
    reg  [1:0]   slope;
    reg  [15:0]  center;
    reg  [15:0]  surr;
    reg  [15:0]  cmix;
    reg  [15:0]  smix;
    reg  [15:0]  knee;
    reg  [15:0]  hold;
    wire         in_ready;
    wire         out_valid;
    wire         out_ready;
    wire [15:0]  line_word;
    wire         line_limit;
    wire         frame_word;
    wire [15:0]  rf_word;
    wire         rf_limit;
    wire [7:0]   entries;
    wire [7:0]   frames;
    wire [15:0]  s_line;
    wire         s_limit;
    wire [15:0]  s_rf;
    wire         s_rf_limit;
    integer      err_count;
    integer      samples_checked;
    integer      taken;
    dgw_gain_word_gen #(.CH(6), .W(16), .SPN(SPN), .BPF(6)) u_dgw_gain_word_gen (
        .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_in_valid(in_valid),
        .o_in_ready(in_ready), .i_ch_loud(ch_loud), .i_ch_active(ch_active),
        .i_peak_front(front), .i_peak_center(center),
        .i_peak_surr(surr), .i_cmix_gain(cmix),
        .i_smix_gain(smix), .i_dial_level(dial), .i_line_knee(knee),
        .i_line_slope(slope), .i_rf_knee(knee), .i_rf_slope(slope),
        .o_out_valid(out_valid), .i_out_ready(out_ready),
        .o_line_word(line_word), .o_line_limit(line_limit),
        .o_frame_word(frame_word), .o_rf_word(rf_word),
        .o_rf_limit(rf_limit),
        .o_dial_out());
    dgw_sink u_dgw_sink (
        .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_slow(slow),
        .i_out_valid(out_valid), .o_out_ready(out_ready),
        .i_line_word(line_word), .i_line_limit(line_limit),
        .i_frame_word(frame_word), .i_rf_word(rf_word), .o_entries(entries),
        .o_frames(frames), .o_line_word(s_line), .o_line_limit(s_limit),
        .i_rf_limit(rf_limit), .o_rf_word(s_rf), .o_rf_limit(s_rf_limit));
    initial begin
        i_clock = 1'b0;
        forever #12.5 i_clock = ~i_clock;
    end
    always @(posedge i_clock) begin
        if (i_sys_rst)
            taken <= 0;
        else if (in_valid && in_ready)
            taken <= taken + 1;
    end
    task test_done;
        begin
            $display("checked %0d mismatches %0d", samples_checked, err_count);
            if (err_count == 0 && samples_checked > 0)
                $display("ALL CHECKS OK");
            else
                $display("CHECKS NOT OK");
            $finish;
        end
    endtask
    task chk(input string name, input [15:0] exp, input [15:0] seen);
        begin
            samples_checked = samples_checked + 1;
            if (seen !== exp) begin
                err_count = err_count + 1;
                $display("unexpected %s expected %h seen %h", name, exp, seen);
            end
        end
    endtask
    // restart with new settings, a reset in mid-run each time
    task restart(input [15:0] loud, input [5:0] act, input [1:0] slp,
                 input [15:0] pk, input [15:0] dl);
        begin
            @(negedge i_clock);
            i_sys_rst = 1'b1;
            ch_loud   = {6{loud}};
            ch_active = act;
            slope     = slp;
            front     = pk;
            dial      = dl;
            center    = 16'h0000;
            surr      = 16'h0000;
            cmix      = 16'h0000;
            smix      = 16'h0000;
            knee      = 16'h0000;
            repeat (2) @(negedge i_clock);
            i_sys_rst = 1'b0;
        end
    endtask
    task feed(input integer blocks);
        integer k;
        begin
            in_valid = 1'b1;
            k = 0;
            while ((taken < blocks*BLK || entries != blocks) && k < 3000) begin
                @(negedge i_clock);
                if (taken == blocks*BLK)
                    in_valid = 1'b0;
                k = k + 1;
            end
            in_valid = 1'b0;
            chk("entries", blocks, entries);
            chk("frames", blocks/6, frames);
            if (k >= 3000) begin
                err_count = err_count + 1;
                $display("unexpected timeout expected %0d entries seen %0d",
                         blocks, entries);
                test_done;
            end
        end
    endtask
    task t_quiet;
        begin
            restart(16'h0000, 6'h3F, 2'h0, 16'h0000, 16'h0000);
            feed(6);
            chk("line word", 16'h0000, s_line);
            chk("line limit", 16'h0000, s_limit);
            chk("rf word", 16'h0000, s_rf);
            chk("rf limit", 16'h0000, s_rf_limit);
            $display("test quiet done");
        end
    endtask
    task t_inactive;
        begin
            restart(16'h0200, 6'h00, 2'h3, 16'h0000, 16'h0000);
            feed(6);
            chk("inactive word", 16'h0000, s_line);
            $display("test inactive done");
        end
    endtask
    task t_active;
        begin
            restart(16'h0200, 6'h3F, 2'h3, 16'h0000, 16'h0000);
            knee = 16'h0400;
            slow = 1'b1;
            feed(12);
            slow = 1'b0;
            chk("line sign", 16'h0001, s_line[15]);
            chk("rf sign", 16'h0001, s_rf[15]);
            chk("line step", 16'h0000, s_line[1:0]);
            chk("rf step", 16'h0000, s_rf[2:0]);
            hold    = s_line;
            ch_loud = 96'h0;
            feed(18);
            chk("decay rise", 16'h0001,
                $signed(s_line) > $signed(hold));
            $display("test active done");
        end
    endtask
    task t_limit;
        begin
            restart(16'h0000, 6'h3F, 2'h0, 16'h0100, 16'hFF9C);
            center = 16'h00C8;
            cmix   = 16'h0038;
            surr   = 16'h0080;
            smix   = 16'h0010;
            feed(6);
            chk("limit", 16'h0001, s_limit);
            chk("limited sign", 16'h0001, s_line[15]);
            chk("limited word", 16'hFED4, s_line);
            chk("rf limit", 16'h0001, s_rf_limit);
            chk("rf limited word", 16'hFED0, s_rf);
            $display("test limit done");
        end
    endtask
    initial begin
        err_count       = 0;
        samples_checked = 0;
        in_valid        = 1'b0;
        slow            = 1'b0;
        ch_loud         = 96'h0;
        ch_active       = 6'h00;
        front           = 16'h0000;
        dial            = 16'h0000;
        slope           = 2'h0;
        i_sys_rst       = 1'b1;
        repeat (5) @(negedge i_clock);
        i_sys_rst = 1'b0;
        t_quiet;
        t_inactive;
        t_active;
        t_limit;
        test_done;
    end
endmodule // dgw_gain_word_gen_bench
bind dgw_gain_word_gen dgw_gain_word_gen_asserts #(
    .W(W), .SPN(SPN), .BPF(BPF)) u_dgw_gain_word_gen_asserts (
    .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_in_valid(i_in_valid),
    .o_in_ready(o_in_ready), .o_out_valid(o_out_valid),
    .i_out_ready(i_out_ready), .o_line_word(o_line_word),
    .o_line_limit(o_line_limit), .o_frame_word(o_frame_word),
    .o_rf_word(o_rf_word), .o_dial_out(o_dial_out),
    .i_dial_level(i_dial_level));
